// *** adc_ctrl_pkg.sv ***
// Purpose: constants for the converter sequencer and DMA control block
// Assumes: 16-bit control registers on a plain strobe port
// Notes: register indices are plain word addresses
package adc_ctrl_pkg;
  localparam logic [1:0] ADDR_CTRL_ONE = 2'h0;
  localparam logic [1:0] ADDR_CTRL_TWO = 2'h1;
  localparam logic [1:0] ADDR_RESULT = 2'h2;
  localparam logic [1:0] ADDR_BUFLEN = 2'h3;
  // control one fields
  localparam int C1_ON = 15;
  localparam int C1_SIDL = 13;
  localparam int C1_BBM = 12;
  localparam int C1_RES = 10;
  localparam int C1_FORM = 8;
  localparam int C1_SRC = 5;
  localparam int C1_SIM = 3;
  localparam int C1_AUTO_START_SAMPLING = 2;
  localparam int C1_SAMPLE_ACTIVE = 1;
  localparam int C1_DONE = 0;
  localparam logic [15:0] C1_WMASK = 16'hB7EC;
  // control two fields
  localparam int C2_VCFG = 13;
  localparam int C2_SCAN = 10;
  localparam int C2_CHPS = 8;
  localparam int C2_FILL_HALF_STATUS = 7;
  localparam int C2_SMPI = 2;
  localparam int C2_BUFFER_FILL_MODE = 1;
  localparam int C2_ALTERNATE_INPUT_MODE = 0;
  localparam logic [15:0] C2_WMASK = 16'hE73F;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // trigger codes
  localparam logic [2:0] SRC_SOFT = 3'h0;
  localparam logic [2:0] SRC_PIN = 3'h1;
  localparam logic [2:0] SRC_TMR3 = 3'h2;
  localparam logic [2:0] SRC_TMR5 = 3'h4;
  localparam logic [2:0] SRC_AUTO = 3'h7;
  localparam logic [3:0] HALF_OFFSET = 4'h8;
  // timing
  localparam int CLK_MHZ = 50;
  localparam int CONV_NS = 240;
  localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int AUTO_NS = 100;
  localparam int AUTO_CYC = (AUTO_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} seq_state_t;
endpackage

// *** adc_sequencer_dma_control.sv ***
// Purpose: sequencer, result formatting and DMA request/address for the SAR converter
// Assumes: analog core converts CONV_CYC cycles after sampling ends
// Notes: reads return data one cycle after the read strobe
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module adc_sequencer_dma_control
  import adc_ctrl_pkg::*;
#(
  parameter int RES_W = 12
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic [1:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  // device and trigger inputs
  input wire logic idleMode,
  input wire logic timerThreeMatch,
  input wire logic timerFiveMatch,
  input wire logic externalInterruptPinZero,
  input wire logic [RES_W-1:0] rawResult,
  // analog front end control
  output logic converterOn,
  output logic sampleHold,
  output logic convertStart,
  output logic useSampleB,
  output logic [1:0] channelIndex,
  output logic [2:0] referenceConfig,
  // dma side
  output logic dmaRequest,
  output logic [10:0] dmaAddress,
  output logic [15:0] resultData,
  output logic conversionInterruptFlag
);

  // ----------------------------------------
  // registers and helpers
  // ----------------------------------------
  logic [15:0] ctrlOne_q, ctrlOne_d, ctrlTwo_q, ctrlTwo_d;
  logic [2:0] bufLen_q, bufLen_d;
  seq_state_t state_q, state_d;
  logic [7:0] timer_q, timer_d;
  logic [1:0] chan_q, chan_d;
  logic [3:0] opCount_q, opCount_d;
  logic [3:0] bufPtr_q, bufPtr_d;
  logic [6:0] sgCount_q, sgCount_d;
  logic altB_q, altB_d, pinPrev_q;
  logic [15:0] result_q, result_d, rdata_q, rdata_d;
  logic dmaReq_q, dmaReq_d, irq_q, irq_d, convStart_q, convStart_d;
  logic [10:0] dmaAddr_q, dmaAddr_d;

  logic running, twelveBit, trigger, swEnd, swStart, doneClr;
  logic [1:0] lastChan;

  // format a raw result per mode
  function automatic logic [15:0] fmtResult(input logic [RES_W-1:0] raw, input logic twelve,
                                            input logic [1:0] form);
    logic [15:0] r;
    r = 16'h0000;
    if (twelve) begin
      r = (form == 2'h1) ? {{4{~raw[11]}}, raw[11:0]} : {4'h0, raw[11:0]};
    end else begin
      r = (form == 2'h1) ? {{6{~raw[9]}}, raw[9:0]} : {6'h00, raw[9:0]};
    end
    return r;
  endfunction

  // on and not stopped by idle
  assign running = ctrlOne_q[C1_ON] && !(ctrlOne_q[C1_SIDL] && idleMode);
  assign twelveBit = ctrlOne_q[C1_RES];
  // channels used; only channel zero in 12-bit mode
  assign lastChan = twelveBit ? 2'h0 : (ctrlTwo_q[C2_CHPS+1] ? 2'h3 :
                    (ctrlTwo_q[C2_CHPS] ? 2'h1 : 2'h0));
  assign swEnd = regWrite && regAddr == ADDR_CTRL_ONE && !regWdata[C1_SAMPLE_ACTIVE];
  assign swStart = regWrite && regAddr == ADDR_CTRL_ONE && regWdata[C1_SAMPLE_ACTIVE];
  assign doneClr = regWrite && regAddr == ADDR_CTRL_ONE && !regWdata[C1_DONE];

  // trigger selection
  always_comb begin
    // trigger source decode, reserved codes never fire
    case (ctrlOne_q[C1_SRC+:3])
      SRC_SOFT: trigger = swEnd;
      SRC_PIN: trigger = externalInterruptPinZero && !pinPrev_q;
      SRC_TMR3: trigger = timerThreeMatch;
      SRC_TMR5: trigger = timerFiveMatch;
      SRC_AUTO: trigger = (timer_q == 8'(AUTO_CYC));
      default: trigger = 1'b0;
    endcase
  end

  // ----------------------------------------
  // sequencer next state
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    timer_d = timer_q;
    chan_d = chan_q;
    opCount_d = opCount_q;
    bufPtr_d = bufPtr_q;
    sgCount_d = sgCount_q;
    altB_d = altB_q;
    result_d = result_q;
    dmaReq_d = 1'b0;
    irq_d = 1'b0;
    convStart_d = 1'b0;
    dmaAddr_d = dmaAddr_q;
    ctrlOne_d = ctrlOne_q;
    ctrlTwo_d = ctrlTwo_q;
    bufLen_d = bufLen_q;
    // software writes, writable bits only
    if (regWrite && regAddr == ADDR_CTRL_ONE) begin
      ctrlOne_d = (regWdata & C1_WMASK) | (ctrlOne_q & ~C1_WMASK);
      // software may set sample bit only with auto-start off
      ctrlOne_d[C1_SAMPLE_ACTIVE] = ctrlOne_q[C1_SAMPLE_ACTIVE];
      if (regWdata[C1_SAMPLE_ACTIVE] && !ctrlOne_q[C1_AUTO_START_SAMPLING] && state_q == ST_IDLE)
        ctrlOne_d[C1_SAMPLE_ACTIVE] = 1'b1;
      // writing zero clears flag only, sequence untouched
      ctrlOne_d[C1_DONE] = ctrlOne_q[C1_DONE] && !doneClr; // a hardware set further down wins
    end
    if (regWrite && regAddr == ADDR_CTRL_TWO)
      ctrlTwo_d = (regWdata & C2_WMASK) | (ctrlTwo_q & ~C2_WMASK);
    if (regWrite && regAddr == ADDR_BUFLEN)
      bufLen_d = regWdata[2:0];
    // simultaneous bit absent in 12-bit mode
    if (ctrlOne_d[C1_RES]) ctrlOne_d[C1_SIM] = 1'b0;
    if (ctrlOne_d[C1_RES]) ctrlTwo_d[C2_CHPS+:2] = 2'h0;
    if (!running) begin
      state_d = ST_IDLE;
      timer_d = 8'h00;
      if (!ctrlOne_d[C1_ON]) ctrlOne_d[C1_SAMPLE_ACTIVE] = 1'b0; // new on bit, so on and sample may be written together
    end else begin
      case (state_q)
        ST_IDLE: begin
          timer_d = 8'h00;
          chan_d = 2'h0;
          // auto-start sets the sample bit itself
          if (ctrlOne_q[C1_AUTO_START_SAMPLING]) ctrlOne_d[C1_SAMPLE_ACTIVE] = 1'b1;
          if (ctrlOne_q[C1_AUTO_START_SAMPLING] || ctrlOne_q[C1_SAMPLE_ACTIVE] || swStart) state_d = ST_SAMPLE;
        end
        ST_SAMPLE: begin
          timer_d = (timer_q == 8'hFF) ? timer_q : timer_q + 8'h01;
          if (trigger) begin
            // hardware clears sample bit for every source, software included
            ctrlOne_d[C1_SAMPLE_ACTIVE] = 1'b0;
            // cleared at start of a new conversion
            ctrlOne_d[C1_DONE] = 1'b0;
            convStart_d = 1'b1;
            timer_d = 8'h00;
            state_d = ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          timer_d = timer_q + 8'h01;
          if (timer_q == 8'(CONV_CYC - 1)) begin
            timer_d = 8'h00;
            result_d = fmtResult(rawResult, twelveBit, ctrlOne_q[C1_FORM+:2]);
            // scatter/gather: input index times buffer size plus slot
            dmaAddr_d = 11'({chan_q, 7'h00} >> (3'h7 - bufLen_q)) + 11'(sgCount_q);
            // conversion order shares the stand-alone buffer pointer
            if (ctrlOne_q[C1_BBM]) dmaAddr_d = 11'(bufPtr_q);
            bufPtr_d = bufPtr_q + 4'h1;
            if (chan_q != lastChan && !(ctrlOne_q[C1_SIM])) begin
              chan_d = chan_q + 2'h1;
              convStart_d = 1'b1;
            end else begin
              chan_d = 2'h0;
              ctrlOne_d[C1_DONE] = 1'b1;
              altB_d = ctrlTwo_q[C2_ALTERNATE_INPUT_MODE] ? !altB_q : 1'b0;
              opCount_d = opCount_q + 4'h1;
              if (opCount_q == ctrlTwo_q[C2_SMPI+:4]) begin
                opCount_d = 4'h0;
                irq_d = 1'b1;
                sgCount_d = 7'((sgCount_q + 7'h01) & ((7'h01 << bufLen_q) - 7'h01));
                // alternate halves in buffer fill mode
                ctrlTwo_d[C2_FILL_HALF_STATUS] = ctrlTwo_q[C2_BUFFER_FILL_MODE] ? !ctrlTwo_q[C2_FILL_HALF_STATUS] : 1'b0;
                bufPtr_d = ctrlTwo_d[C2_FILL_HALF_STATUS] ? HALF_OFFSET : 4'h0;
              end
              state_d = ST_IDLE;
            end
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
    // request follows the one-cycle flag pulse
    dmaReq_d = irq_q;
  end

  // read mux
  always_comb begin
    rdata_d = 16'h0000;
    if (regRead) begin
      case (regAddr)
        ADDR_CTRL_ONE: rdata_d = ctrlOne_q;
        ADDR_CTRL_TWO: rdata_d = ctrlTwo_q;
        ADDR_RESULT: rdata_d = result_q;
        ADDR_BUFLEN: rdata_d = {13'h0000, bufLen_q};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrlOne_q <= REG_RESET;
      ctrlTwo_q <= REG_RESET;
      bufLen_q <= 3'h0;
      state_q <= ST_IDLE;
      timer_q <= 8'h00;
      chan_q <= 2'h0;
      opCount_q <= 4'h0;
      bufPtr_q <= 4'h0;
      sgCount_q <= 7'h00;
      altB_q <= 1'b0;
      pinPrev_q <= 1'b0;
      result_q <= 16'h0000;
      rdata_q <= 16'h0000;
      dmaReq_q <= 1'b0;
      irq_q <= 1'b0;
      convStart_q <= 1'b0;
      dmaAddr_q <= 11'h000;
    end else begin
      ctrlOne_q <= ctrlOne_d;
      ctrlTwo_q <= ctrlTwo_d;
      bufLen_q <= bufLen_d;
      state_q <= state_d;
      timer_q <= timer_d;
      chan_q <= chan_d;
      opCount_q <= opCount_d;
      bufPtr_q <= bufPtr_d;
      sgCount_q <= sgCount_d;
      altB_q <= altB_d;
      pinPrev_q <= externalInterruptPinZero;
      result_q <= result_d;
      rdata_q <= rdata_d;
      // one DMA request per flag set
      dmaReq_q <= dmaReq_d;
      irq_q <= irq_d;
      convStart_q <= convStart_d;
      dmaAddr_q <= dmaAddr_d;
    end
  end

  // outputs straight from flops
  assign regRdata = rdata_q;
  assign converterOn = ctrlOne_q[C1_ON];
  assign sampleHold = ctrlOne_q[C1_SAMPLE_ACTIVE];
  assign convertStart = convStart_q;
  assign useSampleB = altB_q;
  assign channelIndex = chan_q;
  // reference pair select passed to the analog core
  assign referenceConfig = ctrlTwo_q[C2_VCFG+:3];
  assign dmaRequest = dmaReq_q;
  assign dmaAddress = dmaAddr_q;
  assign resultData = result_q;
  assign conversionInterruptFlag = irq_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_dma_on_flag;
    @(posedge clk_sys) disable iff (!rst_n) $rose(irq_q) |=> dmaReq_q;
  endproperty
  a_dma_on_flag: assert property (p_dma_on_flag) else $error("no dma request on flag");

  property p_off_idle;
    @(posedge clk_sys) disable iff (!rst_n) !ctrlOne_q[C1_ON] |=> state_q == ST_IDLE;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("module ran while off");

  property p_sidl;
    @(posedge clk_sys) disable iff (!rst_n) (ctrlOne_q[C1_SIDL] && idleMode) |=> state_q == ST_IDLE;
  endproperty
  a_sidl: assert property (p_sidl) else $error("ran through idle");

  property p_sim_zero;
    @(posedge clk_sys) disable iff (!rst_n) ctrlOne_q[C1_RES] |-> !ctrlOne_q[C1_SIM];
  endproperty
  a_sim_zero: assert property (p_sim_zero) else $error("simultaneous bit set in 12-bit");

  property p_reserved_src;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_q == ST_SAMPLE && running && (ctrlOne_q[C1_SRC+:3] inside {3'h3, 3'h5, 3'h6}))
      |=> state_q != ST_CONVERT;
  endproperty
  a_reserved_src: assert property (p_reserved_src) else $error("reserved source ended sampling");

  property p_done_clear;
    @(posedge clk_sys) disable iff (!rst_n) $rose(convStart_q) && state_q == ST_CONVERT
      |-> !ctrlOne_q[C1_DONE];
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done not cleared at start");

  property p_hw_sample_active;
    @(posedge clk_sys) disable iff (!rst_n)
      ($past(state_q) == ST_SAMPLE && state_q == ST_CONVERT) |-> !ctrlOne_q[C1_SAMPLE_ACTIVE];
  endproperty
  a_hw_sample_active: assert property (p_hw_sample_active) else $error("sample bit not cleared");

  property p_fill_half_status;
    @(posedge clk_sys) disable iff (!rst_n) !ctrlTwo_q[C2_BUFFER_FILL_MODE] && $rose(irq_q) |-> !ctrlTwo_q[C2_FILL_HALF_STATUS];
  endproperty
  a_fill_half_status: assert property (p_fill_half_status) else $error("half status toggled without fill mode");

  property p_req_pulse;
    @(posedge clk_sys) disable iff (!rst_n) dmaReq_q |=> !dmaReq_q;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("dma request longer than one cycle");

  property p_auto_start;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_q == ST_IDLE && running && ctrlOne_q[C1_AUTO_START_SAMPLING]) |=> (ctrlOne_q[C1_SAMPLE_ACTIVE] && state_q == ST_SAMPLE);
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("auto-start did not resume sampling");

  property p_irq_rate;
    @(posedge clk_sys) disable iff (!rst_n) $rose(irq_q) |-> opCount_q == 4'h0;
  endproperty
  a_irq_rate: assert property (p_irq_rate) else $error("operation count not restarted at flag");

  property p_bbm_addr;
    @(posedge clk_sys) disable iff (!rst_n)
      (running && state_q == ST_CONVERT && timer_q == 8'(CONV_CYC - 1) && ctrlOne_q[C1_BBM])
      |=> dmaAddr_q == 11'($past(bufPtr_q));
  endproperty
  a_bbm_addr: assert property (p_bbm_addr) else $error("dma address not buffer pointer");

  property p_twelve_chan;
    @(posedge clk_sys) disable iff (!rst_n) (twelveBit && convStart_q) |-> chan_q == 2'h0;
  endproperty
  a_twelve_chan: assert property (p_twelve_chan) else $error("extra channel converted in 12-bit mode");

endmodule // adc_sequencer_dma_control

// *** dma_sink.sv ***
// Purpose: DMA controller model that takes one converter result per request
// Assumes: request is a one-cycle pulse with address and data standing beside it
// Notes: keeps the last word, its address and a running count for the bench
`timescale 1ns/1ns
module dma_sink (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // request side
  input wire logic dmaRequest,
  input wire logic [10:0] dmaAddress,
  input wire logic [15:0] resultData,
  // bench view
  output logic [15:0] reqCount,
  output logic [15:0] lastData,
  output logic [10:0] lastAddr
);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reqCount <= 16'h0000;
      lastData <= 16'h0000;
      lastAddr <= 11'h000;
    end else if (dmaRequest) begin
      reqCount <= reqCount + 16'h0001;
      lastData <= resultData; // taken at the request edge, as a real channel would
      lastAddr <= dmaAddress;
    end
  end
endmodule // dma_sink

// *** tb.sv ***
// Purpose: self-checking bench for the converter sequencer and DMA control
// Assumes: conversion takes CONV_CYC cycles, flag then request one cycle apart
// Notes: all trigger inputs and the idle level are driven, none tied
`timescale 1ns/1ns
module tb;
  import adc_ctrl_pkg::*;
  logic clk_sys, rst_n, regWrite, regRead, idleMode;
  logic timerThreeMatch, timerFiveMatch, externalInterruptPinZero;
  logic [1:0] regAddr;
  logic [15:0] regWdata, regRdata, resultData, reqCount, lastData, v;
  logic [11:0] rawResult;
  logic converterOn, sampleHold, convertStart, useSampleB, dmaRequest, conversionInterruptFlag;
  logic [1:0] channelIndex;
  logic [2:0] referenceConfig;
  logic [10:0] dmaAddress, lastAddr;
  int fails, total_checks, f, k, s0, starts;
  logic [15:0] c1Tbl [4] = '{16'h8000, 16'h8100, 16'h8400, 16'h8500};
  logic [11:0] rawTbl [4] = '{12'h2A5, 12'h0A5, 12'hABC, 12'h2BC};
  logic [15:0] expTbl [4] = '{16'h02A5, 16'hFCA5, 16'h0ABC, 16'hF2BC};
  logic [2:0] srcTbl [5] = '{SRC_PIN, SRC_TMR3, SRC_TMR5, SRC_AUTO, 3'h3};
  adc_sequencer_dma_control u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .idleMode(idleMode),
    .timerThreeMatch(timerThreeMatch), .timerFiveMatch(timerFiveMatch),
    .externalInterruptPinZero(externalInterruptPinZero), .rawResult(rawResult), .converterOn(converterOn),
    .sampleHold(sampleHold), .convertStart(convertStart), .useSampleB(useSampleB), .channelIndex(channelIndex),
    .referenceConfig(referenceConfig), .dmaRequest(dmaRequest), .dmaAddress(dmaAddress),
    .resultData(resultData), .conversionInterruptFlag(conversionInterruptFlag));
  dma_sink u_sink (.clk_sys(clk_sys), .rst_n(rst_n), .dmaRequest(dmaRequest), .dmaAddress(dmaAddress),
    .resultData(resultData), .reqCount(reqCount), .lastData(lastData), .lastAddr(lastAddr));
  // convert-start pulses, each counted one cycle after it stands
  always @(posedge clk_sys) begin
    if (convertStart === 1'b1) starts <= starts + 1;
  end
  // ----------------------------------------
  // clock, shared tasks and verdict
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  // start sampling, end it by the source in c1, count flag pulses in a window
  task automatic runSeq(input logic [15:0] c1, output int flags);
    int i;
    flags = 0;
    wr(ADDR_CTRL_ONE, c1 | 16'h0002);
    if (c1[7:5] === SRC_SOFT) wr(ADDR_CTRL_ONE, c1);
    else if (c1[7:5] !== SRC_AUTO) begin
      @(posedge clk_sys);
      externalInterruptPinZero <= (c1[7:5] !== SRC_TMR3 && c1[7:5] !== SRC_TMR5);
      timerThreeMatch <= (c1[7:5] !== SRC_PIN && c1[7:5] !== SRC_TMR5);
      timerFiveMatch <= (c1[7:5] !== SRC_PIN && c1[7:5] !== SRC_TMR3);
      @(posedge clk_sys);
      {externalInterruptPinZero, timerThreeMatch, timerFiveMatch} <= 3'h0;
    end
    for (i = 0; i < 60; i++) begin
      @(posedge clk_sys);
      #1 if (conversionInterruptFlag === 1'b1) flags++;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog well beyond the roughly 1250 cycles the tests need
  initial begin
    #400000;
    fails++;
    stop_test();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {regWrite, regRead, idleMode, timerThreeMatch, timerFiveMatch, externalInterruptPinZero} = 6'h00;
    regAddr = 2'h0;
    regWdata = 16'h0000;
    rawResult = 12'h000;
    rst_n = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(ADDR_CTRL_ONE, v);
    check(v, REG_RESET); // reset value off
    rd(ADDR_CTRL_TWO, v);
    check(v, REG_RESET); // fill status clear
    wr(ADDR_CTRL_TWO, 16'hFFFF);
    rd(ADDR_CTRL_TWO, v);
    check(v, C2_WMASK); // status bit read-only
    check({13'h0, referenceConfig}, 16'h0007); // reference field drives out
    wr(ADDR_CTRL_TWO, 16'h0000);
    wr(ADDR_CTRL_ONE, 16'h0001);
    rd(ADDR_CTRL_ONE, v);
    check(v, 16'h0000); // done ignores a one
    $display("test registers done");
    for (k = 0; k < 4; k++) begin
      wr(ADDR_CTRL_ONE, 16'h0000);
      rawResult <= rawTbl[k];
      runSeq(c1Tbl[k], f);
      check(resultData, expTbl[k]); // result format
      check(lastData, expTbl[k]); // word reached the channel
      check(f[15:0], 16'h0001); // software zero ends sampling
      rd(ADDR_CTRL_ONE, v);
      check(v, c1Tbl[k] | 16'h0001); // done set at end
      check({15'h0, converterOn}, 16'h0001); // running while on
      wr(ADDR_CTRL_ONE, c1Tbl[k] | 16'h0002);
      rd(ADDR_CTRL_ONE, v);
      check(v, c1Tbl[k] | 16'h0002); // clear keeps sampling
      check({15'h0, sampleHold}, 16'h0001); // sampling after set
    end
    wr(ADDR_RESULT, 16'hFFFF);
    rd(ADDR_RESULT, v);
    check(v, expTbl[3]); // result word read-only
    wr(ADDR_CTRL_ONE, 16'h0000);
    #1 check({15'h0, converterOn}, 16'h0000); // off after clear
    $display("test formats done");
    // trigger sources, last entry reserved with every trigger pulsed
    for (k = 0; k < 5; k++) begin
      wr(ADDR_CTRL_ONE, 16'h0000);
      rawResult <= 12'h155;
      runSeq(16'h8000 | {8'h0, srcTbl[k], 5'h0}, f);
      check(f[15:0], (k < 4) ? 16'h0001 : 16'h0000); // source ends sampling
      check({15'h0, sampleHold}, (k < 4) ? 16'h0000 : 16'h0001); // hardware clears sample bit
    end
    $display("test triggers done");
    wr(ADDR_CTRL_ONE, 16'h0000);
    wr(ADDR_CTRL_TWO, 16'h0004);
    runSeq(16'h8000, f);
    check(f[15:0], 16'h0000); // no flag after first of two
    runSeq(16'h8000, f);
    check(f[15:0], 16'h0001); // flag after second
    check(reqCount, 16'h0009); // one request per flag
    wr(ADDR_CTRL_TWO, 16'h0000);
    $display("test increment rate done");
    wr(ADDR_CTRL_ONE, 16'h0000);
    idleMode <= 1'b1;
    runSeq(16'hA0E0, f);
    check(f[15:0], 16'h0000); // stops in idle
    wr(ADDR_CTRL_ONE, 16'h0000);
    runSeq(16'h80E0, f);
    check(f[15:0], 16'h0001); // continues through idle
    idleMode <= 1'b0;
    wr(ADDR_CTRL_ONE, 16'h0000);
    runSeq(16'h80E4, f);
    check({15'h0, f > 1}, 16'h0001); // auto-start repeats
    wr(ADDR_CTRL_ONE, 16'h0000);
    $display("test idle and auto-start done");
    // four channels, four words per input, sample B every other sequence
    wr(ADDR_BUFLEN, 16'h0002);
    wr(ADDR_CTRL_TWO, 16'h0201);
    for (k = 0; k < 2; k++) begin
      wr(ADDR_CTRL_ONE, 16'h0000);
      s0 = starts;
      runSeq(16'h8000, f);
      check(f[15:0], 16'h0001); // one flag per four-channel sequence
      check(16'(starts - s0), 16'h0004); // four channels converted
      check({5'h00, lastAddr}, 16'h000C + 16'(k)); // last input index times size plus slot
      check({15'h0, useSampleB}, (k == 0) ? 16'h0001 : 16'h0000); // sample B on alternate sequences
      check({14'h0, channelIndex}, 16'h0000); // back to channel zero
    end
    // conversion order with the half-buffer toggle
    wr(ADDR_CTRL_TWO, 16'h0202);
    for (k = 0; k < 2; k++) begin
      wr(ADDR_CTRL_ONE, 16'h0000);
      runSeq(16'h9000, f);
      check({5'h00, lastAddr}, (k == 0) ? 16'h0003 : 16'h000B); // conversion order address
      rd(ADDR_CTRL_TWO, v);
      check(v, (k == 0) ? 16'h0282 : 16'h0202); // fill half toggles per flag
    end
    wr(ADDR_CTRL_ONE, 16'h0000);
    $display("test dma addressing done");
    stop_test();
  end
endmodule // tb
